/* File: lfw_pkg.sv */
// Package for the flash write-protect link: field codes, address layout, sectors, link states.
// Assumes a single 33 MHz-class link clock shared by both ends.
package lfw_pkg;
    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [3:0] LFW_START = 4'h0;
    localparam logic [1:0] LFW_CYC_MEM = 2'h1;
    localparam logic [3:0] LFW_CYC_WRITE = 4'h6;
    localparam logic [3:0] LFW_TAR_ONES = 4'hF;
    localparam logic [3:0] LFW_SYNC_READY = 4'h0;
    localparam int LFW_ADDR_NIBBLES = 8;
    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int LFW_ARRAY_SEL_BIT = 23;
    localparam int LFW_ID_HI = 22;
    localparam int LFW_ID_LO = 20;
    localparam int LFW_SECT_HI = 19;
    localparam int LFW_SECT_LO = 16;
    localparam logic [3:0] LFW_TOP_SECTOR = 4'hF;
    // ------------------------------------------------------------
    // Link states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LFW_IDLE = 4'h0,
        LFW_CYC = 4'h1,
        LFW_ADDR = 4'h2,
        LFW_DLO = 4'h3,
        LFW_DHI = 4'h4,
        LFW_TAR0 = 4'h5,
        LFW_TAR1 = 4'h6,
        LFW_SYNC = 4'h7,
        LFW_RTAR0 = 4'h8,
        LFW_RTAR1 = 4'h9
    } lfw_state_type;
endpackage

/* File: lfw_if.sv */
// Interface carrying the four shared data lines and the frame strobe.
// The interface resolves the shared lines from the two enables.
`timescale 1ns/1ns
`default_nettype none
interface lfw_if;
    logic frame_n;
    logic [3:0] host_lad;
    logic host_lad_oe;
    logic [3:0] dev_lad;
    logic dev_lad_oe;
    logic [3:0] lad;
    // Wire level: whoever enables drives, the host if both do; otherwise pulled high.
    assign lad = host_lad_oe ? host_lad : (dev_lad_oe ? dev_lad : 4'hF);
    modport host (output frame_n, output host_lad, output host_lad_oe,
        input lad);
    modport dev (input frame_n, output dev_lad, output dev_lad_oe,
        input lad);
endinterface
`default_nettype wire

/* File: lfw_host.sv */
// Host end: issues one memory write cycle per request on the link.
// Assumes the device end answers with a ready sync in the sync slot.
`timescale 1ns/1ns
`default_nettype none
module lfw_host (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    // Link
    lfw_if.host LINK,
    // User request
    input wire logic REQ_IN,
    input wire logic [31:0] ADDR_IN,
    input wire logic [7:0] DATA_IN,
    input wire logic ABORT_IN,
    output logic BUSY_OUT,
    output logic DONE_OUT
);
    import lfw_pkg::*;

    lfw_state_type st_q;
    logic [2:0] cnt_q;
    logic [31:0] addr_q;
    logic [7:0] data_q;
    logic [3:0] lad_q;
    logic oe_q;
    logic frame_n_q;
    logic done_q;
    logic [1:0] rx_q;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign LINK.frame_n = frame_n_q;
    assign LINK.host_lad = lad_q;
    assign LINK.host_lad_oe = oe_q;
    assign BUSY_OUT = (st_q != LFW_IDLE);
    assign DONE_OUT = done_q;

    // Sequencer: start, type, address, data, turnaround, hand-back.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            st_q <= LFW_IDLE;
            cnt_q <= 3'h0;
            addr_q <= 32'h0000_0000;
            data_q <= 8'h00;
            lad_q <= 4'hF;
            oe_q <= 1'b0;
            frame_n_q <= 1'b1;
            done_q <= 1'b0;
            rx_q <= 2'h0;
        end else if (CE_IN) begin
            done_q <= 1'b0;
            frame_n_q <= 1'b1;
            if (ABORT_IN && st_q != LFW_IDLE) begin
                // Abort: frame low with an idle pattern cancels the cycle.
                frame_n_q <= 1'b0;
                lad_q <= 4'hF;
                oe_q <= 1'b1;
                st_q <= LFW_IDLE;
            end else begin
                case (st_q)
                    LFW_IDLE: begin
                        oe_q <= 1'b0;
                        if (REQ_IN) begin
                            addr_q <= ADDR_IN;
                            data_q <= DATA_IN;
                            frame_n_q <= 1'b0;
                            lad_q <= LFW_START;
                            oe_q <= 1'b1;
                            st_q <= LFW_CYC;
                        end
                    end
                    LFW_CYC: begin
                        lad_q <= LFW_CYC_WRITE;
                        cnt_q <= 3'h0;
                        st_q <= LFW_ADDR;
                    end
                    LFW_ADDR: begin
                        lad_q <= addr_q[31:28];
                        addr_q <= {addr_q[27:0], 4'h0};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'(LFW_ADDR_NIBBLES - 1)) begin
                            st_q <= LFW_DLO;
                        end
                    end
                    LFW_DLO: begin
                        lad_q <= data_q[3:0];
                        st_q <= LFW_DHI;
                    end
                    LFW_DHI: begin
                        lad_q <= data_q[7:4];
                        st_q <= LFW_TAR0;
                    end
                    LFW_TAR0: begin
                        lad_q <= LFW_TAR_ONES;
                        st_q <= LFW_TAR1;
                    end
                    LFW_TAR1: begin
                        oe_q <= 1'b0;
                        rx_q <= 2'h0;
                        st_q <= LFW_SYNC;
                    end
                    LFW_SYNC: begin
                        // Wait out the device's sync and its turnaround.
                        rx_q <= rx_q + 2'h1;
                        if (rx_q == 2'h3) begin
                            st_q <= LFW_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                    default: begin
                        st_q <= LFW_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: lfw_dev.sv */
// Device end: memory write target with two hardware protect pins.
// Assumes the host end of the link and a neighbouring command engine
// that reports busy/suspended through plain ports.
`timescale 1ns/1ns
`default_nettype none
module lfw_dev (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    // Link
    lfw_if.dev LINK,
    // Straps and protect pins
    input wire logic [2:0] ID_STRAP_IN,
    input wire logic TOP_SECTOR_PROTECT_N_IN,
    input wire logic WP_N_IN,
    // Register lock bit of the addressed sector, from neighbour logic
    input wire logic REG_WRITE_LOCK_IN,
    // Command engine status
    input wire logic OP_BUSY_IN,
    input wire logic OP_SUSPENDED_IN,
    // Command engine hand-off
    output logic WR_VALID_OUT,
    output logic WR_ARRAY_OUT,
    output logic [31:0] WR_ADDR_OUT,
    output logic [7:0] WR_DATA_OUT,
    output logic WR_PROTECTED_OUT,
    output logic TOP_LOCK_OUT,
    output logic OTHER_LOCK_OUT
);
    import lfw_pkg::*;

    lfw_state_type st_q;
    logic [2:0] cnt_q;
    logic [31:0] addr_q;
    logic [3:0] dlo_q;
    logic hit_q;
    logic [3:0] lad_q;
    logic oe_q;
    logic wr_valid_q;
    logic wr_array_q;
    logic [31:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_prot_q;
    logic top_lock_q;
    logic other_lock_q;
    logic [1:0] tp_sync_q;
    logic [1:0] wp_sync_q;

    // True when the addressed sector is held by the latched pins.
    function automatic logic lfw_pin_guard(input logic [3:0] sector,
        input logic top_lock, input logic other_lock);
        if (sector == LFW_TOP_SECTOR) begin
            lfw_pin_guard = top_lock;
        end else begin
            lfw_pin_guard = other_lock;
        end
    endfunction

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign LINK.dev_lad = lad_q;
    // Frame low floats the lines at once, not one clock later.
    assign LINK.dev_lad_oe = oe_q & LINK.frame_n;
    assign WR_VALID_OUT = wr_valid_q;
    assign WR_ARRAY_OUT = wr_array_q;
    assign WR_ADDR_OUT = wr_addr_q;
    assign WR_DATA_OUT = wr_data_q;
    assign WR_PROTECTED_OUT = wr_prot_q;
    assign TOP_LOCK_OUT = top_lock_q;
    assign OTHER_LOCK_OUT = other_lock_q;

    // Protect pins are board levels, so they pass two flops first.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            tp_sync_q <= 2'h3;
            wp_sync_q <= 2'h3;
        end else if (CE_IN) begin
            tp_sync_q <= {tp_sync_q[0], TOP_SECTOR_PROTECT_N_IN};
            wp_sync_q <= {wp_sync_q[0], WP_N_IN};
        end
    end

    // Lock state follows the pins only while no operation is busy or
    // suspended; a change is thus taken when the operation finishes.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            top_lock_q <= 1'b0;
            other_lock_q <= 1'b0;
        end else if (CE_IN) begin
            if (!OP_BUSY_IN && !OP_SUSPENDED_IN) begin
                top_lock_q <= ~tp_sync_q[1];
                other_lock_q <= ~wp_sync_q[1];
            end
        end
    end

    // Link state machine; an abort only resets this machine and never
    // touches the command engine, which has no cancel input here.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            st_q <= LFW_IDLE;
            cnt_q <= 3'h0;
            addr_q <= 32'h0000_0000;
            dlo_q <= 4'h0;
            hit_q <= 1'b0;
        end else if (CE_IN) begin
            if (!LINK.frame_n) begin
                // Any start seen under frame restarts; the last one wins.
                if (LINK.lad == LFW_START) begin
                    st_q <= LFW_CYC;
                end else begin
                    st_q <= LFW_IDLE;
                end
            end else begin
                case (st_q)
                    LFW_IDLE: begin
                        st_q <= LFW_IDLE;
                    end
                    LFW_CYC: begin
                        cnt_q <= 3'h0;
                        if (LINK.lad[3:2] == LFW_CYC_MEM && LINK.lad[1]) begin
                            st_q <= LFW_ADDR;
                        end else begin
                            st_q <= LFW_IDLE;
                        end
                    end
                    LFW_ADDR: begin
                        addr_q <= {addr_q[27:0], LINK.lad};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'(LFW_ADDR_NIBBLES - 1)) begin
                            st_q <= LFW_DLO;
                        end
                    end
                    LFW_DLO: begin
                        dlo_q <= LINK.lad;
                        hit_q <= (addr_q[LFW_ID_HI:LFW_ID_LO] ==
                            ID_STRAP_IN);
                        st_q <= LFW_DHI;
                    end
                    LFW_DHI: begin
                        st_q <= hit_q ? LFW_TAR0 : LFW_IDLE;
                    end
                    LFW_TAR0: begin
                        st_q <= LFW_TAR1;
                    end
                    LFW_TAR1: begin
                        st_q <= LFW_SYNC;
                    end
                    LFW_SYNC: begin
                        st_q <= LFW_RTAR0;
                    end
                    LFW_RTAR0: begin
                        st_q <= LFW_RTAR1;
                    end
                    LFW_RTAR1: begin
                        st_q <= LFW_IDLE;
                    end
                    default: begin
                        st_q <= LFW_IDLE;
                    end
                endcase
            end
        end
    end

    // Line drive: registered so the value appears in the following clock.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            lad_q <= 4'hF;
            oe_q <= 1'b0;
        end else if (CE_IN) begin
            lad_q <= 4'hF;
            oe_q <= 1'b0;
            if (LINK.frame_n) begin
                if (st_q == LFW_TAR1) begin
                    lad_q <= LFW_SYNC_READY;
                    oe_q <= 1'b1;
                end else if (st_q == LFW_SYNC) begin
                    lad_q <= LFW_TAR_ONES;
                    oe_q <= 1'b1;
                end
            end
        end
    end

    // Hand-off only after the high nibble: an earlier abort leaves the
    // array alone. The register lock bit, or the pin lock of the addressed sector's group, marks the write protected.
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            wr_valid_q <= 1'b0;
            wr_array_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
            wr_data_q <= 8'h00;
            wr_prot_q <= 1'b0;
        end else if (CE_IN) begin
            wr_valid_q <= 1'b0;
            if (LINK.frame_n && st_q == LFW_DHI && hit_q) begin
                wr_valid_q <= 1'b1;
                wr_data_q <= {LINK.lad, dlo_q};
                wr_addr_q <= addr_q;
                wr_array_q <= addr_q[LFW_ARRAY_SEL_BIT];
                wr_prot_q <= REG_WRITE_LOCK_IN |
                    lfw_pin_guard(addr_q[LFW_SECT_HI:LFW_SECT_LO],
                    top_lock_q, other_lock_q);
            end
        end
    end
endmodule
`default_nettype wire

/* File: lfw_link_checker.sv */
// Checker for the shared link between the host and device ends.
// Assumes it sits beside the interface and sees its plain signals.
`timescale 1ns/1ns
`default_nettype none
module lfw_link_checker
    import lfw_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // Link signals
    input wire logic frame_n,
    input wire logic [3:0] host_lad,
    input wire logic host_lad_oe,
    input wire logic [3:0] dev_lad,
    input wire logic dev_lad_oe,
    input wire logic [3:0] lad
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Start nibble followed by a memory write type nibble.
    sequence s_wr_head;
        !frame_n && host_lad_oe && host_lad == LFW_START
        ##1 frame_n && (lad & 4'hE) == LFW_CYC_WRITE;
    endsequence
    // Address, data and first turnaround clock with no abort.
    sequence s_wr_body;
        s_wr_head ##1 frame_n [*8] ##1 frame_n [*3];
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_START_NIBBLE: assert property (
        (!frame_n && host_lad_oe ##1 frame_n && host_lad_oe)
        |-> $past(lad) == LFW_START) else $error("bad start nibble");
    AST_HOST_TAR: assert property (
        s_wr_body |-> host_lad_oe && lad == LFW_TAR_ONES ##1 !host_lad_oe)
        else $error("host turnaround wrong");
    AST_SYNC_READY: assert property (
        s_wr_body ##2 dev_lad_oe |-> lad == LFW_SYNC_READY
        ##1 dev_lad_oe && lad == LFW_TAR_ONES ##1 !dev_lad_oe)
        else $error("sync or release wrong");
    AST_NO_CLASH: assert property (
        !(host_lad_oe && dev_lad_oe)) else $error("both ends drive");
    AST_DEV_AFTER_TAR: assert property (
        $rose(dev_lad_oe) |-> $past(host_lad_oe, 2) && !$past(host_lad_oe)
        && $past(lad, 2) == LFW_TAR_ONES) else $error("device drove early");
    AST_DEV_WRITE_ONLY: assert property (
        $rose(dev_lad_oe) |-> ($past(lad, 13) & 4'hE) == LFW_CYC_WRITE
        && !$past(frame_n, 14)) else $error("device drove off a write");
    AST_ABORT_FLOAT: assert property (
        !frame_n |=> !dev_lad_oe) else $error("no float after frame low");
    // The drive decision is registered, so frame must have been high
    // in the clock before as well as in the clock of the drive.
    AST_DEV_FRAME_HIGH: assert property (
        dev_lad_oe |-> frame_n && $past(frame_n))
        else $error("device drives in frame");
endmodule
`default_nettype wire

/* File: lpc_flash_write_protect_test.sv */
// Testbench joining the host and device ends over one link.
// Assumes the package, interface, both ends and checker compile first.
`timescale 1ns/1ns
`default_nettype none
module lpc_flash_write_protect_test;
    import lfw_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic abort = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0] data = 8'h0;
    logic top_n = 1'b1;
    logic wp_n = 1'b1;
    logic eng_busy = 1'b0;
    logic susp = 1'b0;
    logic reg_lock = 1'b0;
    logic [2:0] strap = 3'h5;
    int done_seen = 0;
    logic busy, done, wr_valid, wr_array, wr_prot, top_lock, other_lock;
    logic seen_arr, seen_prot;
    logic [31:0] wr_addr;
    logic [7:0] wr_data;
    logic [47:0] host_seq;
    logic [7:0] dev_seq;
    int wr_seen = 0;
    int dev_drv = 0;
    int cycles = 0;
    int bad_count = 0;
    int total_checks = 0;
    lfw_if lfw_if_i ();
    lfw_host lfw_host_i (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n),
        .CE_IN(1'b1), .LINK(lfw_if_i.host), .REQ_IN(req), .ADDR_IN(addr),
        .DATA_IN(data), .ABORT_IN(abort), .BUSY_OUT(busy), .DONE_OUT(done));
    lfw_dev lfw_dev_i (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n),
        .CE_IN(1'b1), .LINK(lfw_if_i.dev), .ID_STRAP_IN(strap),
        .TOP_SECTOR_PROTECT_N_IN(top_n), .WP_N_IN(wp_n),
        .REG_WRITE_LOCK_IN(reg_lock), .OP_BUSY_IN(eng_busy),
        .OP_SUSPENDED_IN(susp), .WR_VALID_OUT(wr_valid),
        .WR_ARRAY_OUT(wr_array), .WR_ADDR_OUT(wr_addr),
        .WR_DATA_OUT(wr_data), .WR_PROTECTED_OUT(wr_prot),
        .TOP_LOCK_OUT(top_lock), .OTHER_LOCK_OUT(other_lock));
    lfw_link_checker lfw_link_checker_i (.REF_CLK_IN(ref_clk),
        .RST_N_IN(rst_n), .frame_n(lfw_if_i.frame_n),
        .host_lad(lfw_if_i.host_lad), .host_lad_oe(lfw_if_i.host_lad_oe),
        .dev_lad(lfw_if_i.dev_lad), .dev_lad_oe(lfw_if_i.dev_lad_oe),
        .lad(lfw_if_i.lad));
    // Free-running link clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Records wire nibbles and hand-offs; also cuts a hang short.
    always @(posedge ref_clk) begin
        cycles++;
        if (lfw_if_i.host_lad_oe === 1'b1) begin
            host_seq <= {host_seq[43:0], lfw_if_i.lad};
        end
        if (lfw_if_i.dev_lad_oe === 1'b1) begin
            dev_drv++;
            dev_seq <= {dev_seq[3:0], lfw_if_i.lad};
        end
        if (done === 1'b1) begin
            done_seen++;
        end
        if (wr_valid === 1'b1) begin
            wr_seen++;
            seen_arr <= wr_array;
            seen_prot <= wr_prot;
        end
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [47:0] exp,
        input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One host request; ab is the wait count at which to abort.
    task automatic run_write(input logic [31:0] a, input logic [7:0] d,
        input int ab);
        host_seq = 48'h0;
        dev_seq = 8'h0;
        wr_seen = 0;
        dev_drv = 0;
        done_seen = 0;
        addr = a;
        data = d;
        req = 1'b1;
        @(negedge ref_clk);
        req = 1'b0;
        for (int n = 0; n < 40 && busy === 1'b1; n++) begin
            if (n == ab) begin
                abort = 1'b1;
            end
            @(negedge ref_clk);
        end
        abort = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    // Full write, judged on the wire and at the engine hand-off.
    task automatic good_write(input logic [31:0] a, input logic [7:0] d,
        input logic prot);
        logic [47:0] exp_wire;
        exp_wire = {LFW_CYC_WRITE, a, d[3:0], d[7:4], LFW_TAR_ONES};
        run_write(a, d, 99);
        check("wire", exp_wire, host_seq);
        check("sync", 48'h0F, 48'(dev_seq));
        check("pulses", 48'h1, 48'(wr_seen));
        check("done", 48'h1, 48'(done_seen));
        check("address", 48'(a), 48'(wr_addr));
        check("data", 48'(d), 48'(wr_data));
        check("array", 48'(a[23]), 48'(seen_arr));
        check("protect", 48'(prot), 48'(seen_prot));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_basic;
        good_write(32'hFFD31234, 8'hA5, 1'b0);
        good_write(32'hFF530002, 8'h3C, 1'b0);
    endtask
    // Every pin pairing against both sides of the top boundary.
    task automatic t_protect;
        for (int i = 0; i < 4; i++) begin
            top_n = i[0];
            wp_n = i[1];
            repeat (5) @(negedge ref_clk);
            check("top lock", 48'(!top_n), 48'(top_lock));
            check("other lock", 48'(!wp_n), 48'(other_lock));
            good_write(32'hFFDF0000, 8'h40, !top_n);
            good_write(32'hFFDEFFFF, 8'h10, !wp_n);
        end
    endtask
    // Register write lock alone still marks the write as protected.
    task automatic t_reg_lock;
        reg_lock = 1'b1;
        good_write(32'hFFD30000, 8'h22, 1'b1);
        reg_lock = 1'b0;
    endtask
    // Pin changes wait while the engine is suspended or busy.
    task automatic t_defer;
        susp = 1'b1;
        top_n = 1'b0;
        wp_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("held locks", 48'h0, 48'({top_lock, other_lock}));
        susp = 1'b0;
        eng_busy = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("busy locks", 48'h0, 48'({top_lock, other_lock}));
        eng_busy = 1'b0;
        repeat (5) @(negedge ref_clk);
        check("new locks", 48'h3, 48'({top_lock, other_lock}));
        top_n = 1'b1;
        wp_n = 1'b1;
        repeat (5) @(negedge ref_clk);
    endtask
    // Wrong strap bits, then aborts early, at the last data nibble and
    // after the hand-off, when the launched write must stand.
    task automatic t_refuse;
        run_write(32'hFFCF0000, 8'h11, 99);
        check("ignored pulses", 48'h0, 48'(wr_seen));
        check("ignored drive", 48'h0, 48'(dev_drv));
        strap = 3'h4;
        good_write(32'hFFCF0000, 8'h11, 1'b0);
        strap = 3'h5;
        for (int k = 2; k <= 10; k += 8) begin
            run_write(32'hFFD10000, 8'h77, k);
            check("abort pulses", 48'h0, 48'(wr_seen));
            check("abort drive", 48'h0, 48'(dev_drv));
            check("abort done", 48'h0, 48'(done_seen));
            good_write(32'hFFD20001, 8'h5A, 1'b0);
        end
        run_write(32'hFFD30005, 8'h9C, 15);
        check("late pulses", 48'h1, 48'(wr_seen));
        check("late data", 48'h9C, 48'(wr_data));
        check("late drive", 48'h2, 48'(dev_drv));
        good_write(32'hFFD20001, 8'h5A, 1'b0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_basic();
        t_protect();
        t_reg_lock();
        t_defer();
        t_refuse();
        tally_and_finish();
    end
endmodule
`default_nettype wire
